/* File: design/jsd_pkg.sv */
// Constants, codes and types of the secure boundary-scan instruction decoder.
// Assumes a 10-bit instruction register behind a TAP sampled by ref_clk.
//
// Function
// - Secure-enter from core path in user mode puts the device in secure mode.
// - Secure-release from core path in user mode leaves secure mode.
// - Secure mode lets pins use only bypass, sample, extest, idcode, error-detect; release from pins becomes bypass.
// - With tamper protection set, the device starts in secure mode.
// - Volatile-key-clear instruction erases the stored volatile key.
// - Key-cleared-check instruction starts a check that the non-volatile key is erased.
// - AC pulse test makes exactly three output transitions on selected cells.
// - Pulse: data at update, inverted entering idle, data again leaving idle.
// - Toggle train inverts outputs on every falling edge while in idle.
// - Toggle train has its own code and otherwise reuses the pulse behaviour.
// - AC instructions work only in user mode and on the variant having them.
// - No test-reset pin; the TAP resets only through TMS sequencing.
// - All user I/O pins stay high-impedance during configuration through the test port.
// - Identification read is the default instruction after power-up and test-logic-reset.
package jsd_pkg;

    localparam int IR_W = 10;
    localparam int ID_W = 32;
    localparam int AC_CELLS = 4;

    localparam logic [IR_W-1:0] CODE_SECURE_ENTER = 10'h1F0;
    localparam logic [IR_W-1:0] CODE_SECURE_RELEASE = 10'h331;
    localparam logic [IR_W-1:0] CODE_KEY_CLEAR = 10'h029;
    localparam logic [IR_W-1:0] CODE_KEY_CHECK = 10'h013;
    localparam logic [IR_W-1:0] CODE_AC_PULSE = 10'h08F;
    localparam logic [IR_W-1:0] CODE_AC_TRAIN = 10'h04F;
    localparam logic [IR_W-1:0] CODE_BYPASS = 10'h3FF;
    localparam logic [IR_W-1:0] CODE_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] CODE_EXTEST = 10'h00F;
    localparam logic [IR_W-1:0] CODE_IDREAD = 10'h006;
    // Arbitrary value; the error-detect shift code is not fixed here.
    localparam logic [IR_W-1:0] CODE_ERR_SHIFT = 10'h017;

    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
    // Arbitrary identification value.
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jsd_tap_type;

    typedef struct packed {
        logic valid;
        logic [IR_W-1:0] code;
    } jsd_core_req_type;

    typedef struct packed {
        logic secure;
        logic key_clear;
        logic key_check;
        logic [IR_W-1:0] instr;
    } jsd_status_type;

endpackage : jsd_pkg

/* File: design/jsd_top.sv */
// Secure boundary-scan instruction decoder with TAP, ID/bypass chains and AC test drive.
// Assumes TCK, TMS, TDI arrive asynchronously; core request and strap inputs are on ref_clk.
`timescale 1ns/1ns
module jsd_top
    import jsd_pkg::*;
#(
    parameter bit AC_VARIANT = 1'b1
)
(
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic tck, // Test clock pin.
    input wire logic tms, // Test mode select pin.
    input wire logic tdi, // Test data in pin.
    output logic tdo, // Test data out.
    output logic tdo_oe, // Test data out enable.
    input wire jsd_core_req_type core_req, // Core-side instruction request.
    input wire logic user_mode, // Device is in user mode.
    input wire logic tamper_protect, // Tamper-protection strap.
    input wire logic port_config_active, // Configuration through the test port.
    input wire logic [AC_CELLS-1:0] upd_data, // Update data of the AC test cells.
    output logic [AC_CELLS-1:0] ac_out, // Drive value of the AC test cells.
    output logic io_hiz, // Holds user I/O in high impedance.
    output jsd_status_type status // Decoder state and one-cycle key pulses.
);

    // ----------------------------------------------------------------
    // Pin synchronisers and TCK edge detection
    // ----------------------------------------------------------------
    logic tck_m_q, tck_s_q, tck_p_q;
    logic tms_m_q, tms_s_q;
    logic tdi_m_q, tdi_s_q;
    logic tck_rise, tck_fall;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tck_m_q <= 1'b0;
            tck_s_q <= 1'b0;
            tck_p_q <= 1'b0;
            tms_m_q <= 1'b1;
            tms_s_q <= 1'b1;
            tdi_m_q <= 1'b1;
            tdi_s_q <= 1'b1;
        end
        else
        begin
            tck_m_q <= tck;
            tck_s_q <= tck_m_q;
            tck_p_q <= tck_s_q;
            tms_m_q <= tms;
            tms_s_q <= tms_m_q;
            tdi_m_q <= tdi;
            tdi_s_q <= tdi_m_q;
        end
    end

    assign tck_rise = tck_s_q & ~tck_p_q;
    assign tck_fall = ~tck_s_q & tck_p_q;

    // ----------------------------------------------------------------
    // TAP controller
    // ----------------------------------------------------------------
    jsd_tap_type tap_q, tap_d;

    always_comb
    begin
        tap_d = tap_q;
        case (tap_q)
            TAP_RESET: tap_d = tms_s_q ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_d = tms_s_q ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_d = tms_s_q ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_d = tms_s_q ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_d = tms_s_q ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_d = tms_s_q ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_d = tms_s_q ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_d = tms_s_q ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_d = tms_s_q ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_d = tms_s_q ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_d = tms_s_q ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_d = tms_s_q ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_d = tms_s_q ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_d = tms_s_q ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_d = tms_s_q ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_d = tms_s_q ? TAP_SEL_DR : TAP_IDLE;
            default: tap_d = TAP_RESET;
        endcase
    end

    // The TAP leaves reset only through TMS; there is no test-reset input.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tap_q <= TAP_RESET;
        else if (tck_rise)
            tap_q <= tap_d;
    end

    // ----------------------------------------------------------------
    // Instruction filter
    // ----------------------------------------------------------------
    // Returns the instruction that takes effect; refused ones become bypass.
    function automatic logic [IR_W-1:0] filter_code(
        input logic [IR_W-1:0] code,
        input logic from_core,
        input logic secure,
        input logic user
    );
        logic [IR_W-1:0] res;
        logic allowed;
        res = code;
        allowed = (code == CODE_BYPASS) || (code == CODE_SAMPLE) || (code == CODE_EXTEST)
            || (code == CODE_IDREAD) || (code == CODE_ERR_SHIFT);
        if ((code == CODE_SECURE_ENTER) || (code == CODE_SECURE_RELEASE))
        begin
            if (!(from_core && user))
                res = CODE_BYPASS;
        end
        else if (secure && !from_core && !allowed)
            res = CODE_BYPASS;
        else if ((code == CODE_AC_PULSE) || (code == CODE_AC_TRAIN))
        begin
            if (!(user && AC_VARIANT))
                res = CODE_BYPASS;
        end
        return res;
    endfunction : filter_code

    // ----------------------------------------------------------------
    // Instruction register and secure mode
    // ----------------------------------------------------------------
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    logic secure_q;
    logic strap_done_q;
    logic load_pin, load_core, load_any;
    logic [IR_W-1:0] new_code;

    assign load_core = core_req.valid;
    assign load_pin = tck_fall && (tap_q == TAP_UPD_IR) && !load_core;
    assign load_any = load_core || load_pin;
    assign new_code = load_core ? filter_code(core_req.code, 1'b1, secure_q, user_mode)
        : filter_code(ir_sh_q, 1'b0, secure_q, user_mode);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ir_sh_q <= IR_CAPTURE;
        else if (tck_rise && (tap_q == TAP_CAP_IR))
            ir_sh_q <= IR_CAPTURE;
        else if (tck_rise && (tap_q == TAP_SHIFT_IR))
            ir_sh_q <= {tdi_s_q, ir_sh_q[IR_W-1:1]};
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ir_q <= CODE_IDREAD;
        else if (load_any)
            ir_q <= new_code;
        else if (tap_q == TAP_RESET)
            ir_q <= CODE_IDREAD;
    end

    // The tamper strap is caught once, in the first cycle after reset release.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secure_q <= 1'b0;
            strap_done_q <= 1'b0;
        end
        else
        begin
            strap_done_q <= 1'b1;
            if (!strap_done_q)
                secure_q <= tamper_protect;
            else if (load_any && (new_code == CODE_SECURE_ENTER))
                secure_q <= 1'b1;
            else if (load_any && (new_code == CODE_SECURE_RELEASE))
                secure_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Key actions and status
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= '0;
        else
        begin
            status.secure <= secure_q;
            status.instr <= ir_q;
            status.key_clear <= load_any && (new_code == CODE_KEY_CLEAR);
            status.key_check <= load_any && (new_code == CODE_KEY_CHECK);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            io_hiz <= 1'b0;
        else
            io_hiz <= port_config_active;
    end

    // ----------------------------------------------------------------
    // Data register: identification value or one-bit bypass
    // ----------------------------------------------------------------
    logic [ID_W-1:0] dr_q;
    logic id_sel;

    assign id_sel = (ir_q == CODE_IDREAD);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dr_q <= '0;
        else if (tck_rise && (tap_q == TAP_CAP_DR))
            dr_q <= id_sel ? ID_VALUE : '0;
        else if (tck_rise && (tap_q == TAP_SHIFT_DR))
            dr_q <= id_sel ? {tdi_s_q, dr_q[ID_W-1:1]} : {{(ID_W-1){1'b0}}, tdi_s_q};
    end

    // Test data out changes on the falling TCK edge only.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= (tap_q == TAP_SHIFT_IR) || (tap_q == TAP_SHIFT_DR);
            tdo <= (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
        end
    end

    // ----------------------------------------------------------------
    // AC pulse and toggle-train drive
    // ----------------------------------------------------------------
    logic ac_pulse, ac_train, ac_any;
    logic idle_seen_q;
    logic [IR_W-1:0] ac_code;

    // The instruction taking effect at this edge decides, so the update-state drive is not lost.
    assign ac_code = load_any ? new_code : ir_q;
    assign ac_pulse = (ac_code == CODE_AC_PULSE);
    assign ac_train = (ac_code == CODE_AC_TRAIN);
    assign ac_any = ac_pulse || ac_train;

    // Tracks whether the previous falling edge found the TAP in idle.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_seen_q <= 1'b0;
        else if (tck_fall)
            idle_seen_q <= (tap_q == TAP_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ac_out <= '0;
        else if (tck_fall && ac_any)
        begin
            if ((tap_q == TAP_UPD_DR) || (tap_q == TAP_UPD_IR))
                ac_out <= upd_data;
            else if ((tap_q == TAP_IDLE) && (!idle_seen_q || ac_train))
                ac_out <= ~ac_out;
            else if ((tap_q != TAP_IDLE) && idle_seen_q)
                ac_out <= upd_data;
        end
    end

endmodule : jsd_top

/* File: bench/jsd_top_properties.sv */
// Port checks of the secure instruction decoder.
// Assumes one ref_clk domain with reset rst_n.
`timescale 1ns/1ns
module jsd_props
    import jsd_pkg::*;
(
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic tck, // Test clock pin.
    input wire logic tdo, // Test data out.
    input wire jsd_core_req_type core_req, // Core request.
    input wire logic user_mode, // User mode.
    input wire logic tamper_protect, // Strap.
    input wire logic port_config_active, // Configuring.
    input wire logic [AC_CELLS-1:0] ac_out, // AC drive.
    input wire logic io_hiz, // I/O hold.
    input wire jsd_status_type status // Decoder state.
);
    logic [1:0] up_q;
    logic enter_c;
    assign enter_c = core_req.valid && core_req.code == CODE_SECURE_ENTER && user_mode;
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_core(c, u);
        core_req.valid && core_req.code == c && user_mode == u ##1 !core_req.valid;
    endsequence
    a_enter_secure: assert property (s_core(CODE_SECURE_ENTER, 1'b1) |=> status.secure)
        else $error("secure mode not entered");
    a_secure_cause: assert property (up_q == 2'h3 && $rose(status.secure) |-> $past(enter_c, 2))
        else $error("secure mode entered without core request");
    a_release_secure: assert property (s_core(CODE_SECURE_RELEASE, 1'b1) |=> !status.secure)
        else $error("secure mode not left");
    a_tamper_start: assert property (up_q == 2'h2 |-> status.secure == tamper_protect)
        else $error("start mode differs from strap");
    a_key_clear: assert property (core_req.valid && core_req.code == CODE_KEY_CLEAR |=> status.key_clear)
        else $error("no key clear pulse");
    a_key_check: assert property (core_req.valid && core_req.code == CODE_KEY_CHECK |=> status.key_check)
        else $error("no key check pulse");
    a_tdo_low: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved while tck high");
    a_ac_low: assert property ($changed(ac_out) |-> !tck)
        else $error("ac drive moved while tck high");
    a_hiz_cfg: assert property (port_config_active |=> io_hiz)
        else $error("user I/O not held");
    a_core_refused: assert property (s_core(CODE_SECURE_ENTER, 1'b0) |=> status.instr == CODE_BYPASS)
        else $error("refused request not bypass");
    c_enter: cover property (s_core(CODE_SECURE_ENTER, 1'b1));
    c_ac: cover property ($changed(ac_out));
    c_key: cover property (status.key_clear);
endmodule : jsd_props

/* File: bench/jsd_tap_ctrl.sv */
// External test controller model on the four test pins.
// Assumes the decoder samples the pins with its own faster clock.
`timescale 1ns/1ns
module jsd_tap_ctrl
(
    output logic tck, // Test clock, low between frames.
    output logic tms, // Mode select, holds its last value between frames.
    output logic tdi, // Data in, holds its last value between frames.
    input wire logic tdo // Data out.
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic tick(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #40;
        q = tdo;
        tck <= 1'b1;
        #80;
        tck <= 1'b0;
        #40;
    endtask : tick
    task automatic steps(input logic [7:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) tick(m[i], 1'b1, q);
    endtask : steps
    // Reset comes from mode select alone; there is no reset line.
    task automatic tap_reset();
        steps(8'h1F, 5);
        steps(8'h00, 1);
    endtask : tap_reset
    // Only listed codes are handed in here, never a reserved one.
    task automatic load_ir(input logic [9:0] c, output logic [9:0] cap);
        steps(8'h03, 4);
        for (int i = 0; i < 10; i++) tick(i == 9, c[i], cap[i]);
        steps(8'h01, 1);
    endtask : load_ir
    task automatic read_dr(input int n, output logic [31:0] d);
        d = '0;
        steps(8'h01, 3);
        for (int i = 0; i < n; i++) tick(i == n - 1, 1'b0, d[i]);
        steps(8'h01, 2);
    endtask : read_dr
endmodule : jsd_tap_ctrl

/* File: bench/test_jsd_top.sv */
// Self-checking bench of the secure instruction decoder.
// Assumes the pin controller model and the port checker beside the design.
`timescale 1ns/1ns
module test_jsd_top
    import jsd_pkg::*;
;
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, user_mode, tamper_protect;
    logic port_config_active, io_hiz;
    jsd_core_req_type core_req;
    jsd_status_type status;
    logic [AC_CELLS-1:0] upd_data, ac_out, ac_prev;
    logic [9:0] cap;
    logic [31:0] rd;
    int fails = 0, n_checks = 0, n_kc = 0, n_kv = 0, n_ac = 0;
    jsd_top u_dut (.ref_clk, .rst_n, .tck, .tms, .tdi, .tdo, .tdo_oe, .core_req, .user_mode,
        .tamper_protect, .port_config_active, .upd_data, .ac_out, .io_hiz, .status);
    jsd_tap_ctrl u_ctrl (.tck, .tms, .tdi, .tdo);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (status.key_clear === 1'b1) n_kc++;
        if (status.key_check === 1'b1) n_kv++;
        if (ac_out !== ac_prev) n_ac++;
        ac_prev <= ac_out;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic core(input logic [9:0] c);
        @(posedge ref_clk);
        core_req <= '{valid: 1'b1, code: c};
        @(posedge ref_clk);
        core_req.valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : core
    task automatic ir(input logic [9:0] c);
        u_ctrl.load_ir(c, cap);
        u_ctrl.steps(8'h00, 1);
        repeat (3) @(posedge ref_clk);
    endtask : ir
    task automatic t_defaults();
        check("instr", status.instr, CODE_IDREAD);
        u_ctrl.tap_reset();
        // Configuration through the test port stays inactive while the identity is read.
        u_ctrl.read_dr(ID_W, rd);
        check("id", rd, ID_VALUE);
        @(posedge ref_clk);
        port_config_active <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("hiz", io_hiz, 1'b1);
        port_config_active <= 1'b0;
    endtask : t_defaults
    task automatic t_pins();
        int k0;
        k0 = n_kc;
        ir(CODE_KEY_CLEAR);
        check("capture", cap, IR_CAPTURE);
        check("clear", n_kc - k0, 1);
        ir(CODE_SECURE_ENTER);
        check("instr", status.instr, CODE_BYPASS);
        check("secure", status.secure, 1'b0);
        k0 = n_kv;
        core(CODE_KEY_CHECK);
        check("verify", n_kv - k0, 1);
    endtask : t_pins
    task automatic t_secure();
        logic [9:0] ok_c [5] = '{CODE_BYPASS, CODE_SAMPLE, CODE_EXTEST, CODE_IDREAD, CODE_ERR_SHIFT};
        int k0;
        @(posedge ref_clk);
        user_mode <= 1'b1;
        core(CODE_SECURE_ENTER);
        check("secure", status.secure, 1'b1);
        foreach (ok_c[i])
        begin
            ir(ok_c[i]);
            check("allowed", status.instr, ok_c[i]);
        end
        k0 = n_kc;
        ir(CODE_KEY_CLEAR);
        check("blocked", status.instr, CODE_BYPASS);
        check("clear", n_kc - k0, 0);
        ir(CODE_SECURE_RELEASE);
        check("pin release", status.secure, 1'b1);
        core(CODE_SECURE_RELEASE);
        check("release", status.secure, 1'b0);
        @(posedge ref_clk);
        user_mode <= 1'b0;
        core(CODE_SECURE_ENTER);
        check("no user", status.secure, 1'b0);
    endtask : t_secure
    // Drives one AC test with user mode set to u and counts drive changes.
    task automatic t_ac(input logic [9:0] c, input logic u, input int idle_n, input int exp_n);
        int a0;
        @(posedge ref_clk);
        user_mode <= u;
        upd_data <= 4'hA;
        a0 = n_ac;
        u_ctrl.load_ir(c, cap);
        u_ctrl.steps(8'h00, idle_n);
        u_ctrl.steps(8'h01, 1);
        repeat (4) @(posedge ref_clk);
        check("ac data", ac_out, 4'hA);
        check("ac edges", n_ac - a0, exp_n);
        u_ctrl.tap_reset();
    endtask : t_ac
    initial
    begin
        rst_n = 1'b0;
        core_req = '0;
        user_mode = 1'b0;
        tamper_protect = 1'b0;
        port_config_active = 1'b0;
        upd_data = '0;
        ac_prev = '0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_defaults();
        t_pins();
        t_secure();
        t_ac(CODE_AC_PULSE, 1'b1, 4, 3);
        t_ac(CODE_AC_TRAIN, 1'b1, 5, 6);
        t_ac(CODE_AC_PULSE, 1'b0, 4, 0);
        tamper_protect <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("tamper", status.secure, 1'b1);
        finish_test();
    end
    initial
    begin
        #200000;
        fails++;
        finish_test();
    end
endmodule : test_jsd_top
bind jsd_top jsd_props u_props (.ref_clk, .rst_n, .tck, .tdo, .core_req, .user_mode,
    .tamper_protect, .port_config_active, .ac_out, .io_hiz, .status);
